//--- src/bsf_alu.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// One-cycle bit, shift and flag datapath
// ==========================================
module bsf_alu (
  // Operands
  input  wire bsf_pkg::bsf_alu_in_t  a,
  // Results
  output bsf_pkg::bsf_alu_out_t      y
);
  import bsf_pkg::*;

  logic [7:0] hit;
  logic [7:0] sh;

  // One select line per bit position
  for (genvar i = 0; i < 8; i++) begin : g_sel
    assign hit[i] = (a.bitsel == i[2:0]);
  end

  // Flags after a right shift
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r, input logic c);
    logic [7:0] o;
    o         = f;
    o[FLAG_C] = c;
    o[FLAG_Z] = (r == RST_BYTE);
    o[FLAG_N] = r[7];
    o[FLAG_V] = r[7] ^ c;
    return o;
  endfunction

  always_comb begin
    y.dest  = a.dest;
    y.flags = a.flags;
    sh      = a.dest;
    unique case (a.op)
      OP_ROTATE_RIGHT_CARRY: begin
        sh      = {a.flags[FLAG_C], a.dest[7:1]};
        y.dest  = sh;
        y.flags = shift_flags(a.flags, sh, a.dest[0]);
      end
      OP_ARITH_SHIFT_RIGHT: begin
        sh      = {a.dest[7], a.dest[7:1]};
        y.dest  = sh;
        y.flags = shift_flags(a.flags, sh, a.dest[0]);
      end
      OP_SWAP_NIBBLES:     y.dest          = {a.dest[3:0], a.dest[7:4]};
      OP_STATUS_BIT_SET:   y.flags         = a.flags | hit;
      OP_STATUS_BIT_CLEAR: y.flags         = a.flags & ~hit;
      OP_STORE_BIT_TO_T:   y.flags[FLAG_T] = a.src[a.bitsel];
      OP_LOAD_BIT_FROM_T:  y.dest          = (a.dest & ~hit) | (hit & {8{a.flags[FLAG_T]}});
      OP_CARRY_SET:        y.flags[FLAG_C] = 1'b1;
      OP_CARRY_CLEAR:      y.flags[FLAG_C] = 1'b0;
      OP_NEGATIVE_SET:     y.flags[FLAG_N] = 1'b1;
      OP_NEGATIVE_CLEAR:   y.flags[FLAG_N] = 1'b0;
      OP_ZERO_SET:         y.flags[FLAG_Z] = 1'b1;
      OP_ZERO_CLEAR:       y.flags[FLAG_Z] = 1'b0;
      OP_IRQ_GLOBAL_ON:    y.flags[FLAG_I] = 1'b1;
      OP_IRQ_GLOBAL_OFF:   y.flags[FLAG_I] = 1'b0;
      OP_SIGN_SET:         y.flags[FLAG_S] = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

//--- src/bsf_pkg.sv
// ==========================================
// Package
// ==========================================
package bsf_pkg;

  // Bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;
  localparam int         ADDR_LO       = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_DEST  = 8'h00;
  localparam logic [7:0] OFS_SRC   = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_CMD   = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;

  // Command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_BIT_LSB = 8;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Reset values and count width
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam int          COUNT_W   = 16;

  typedef enum logic [3:0] {
    OP_ROTATE_RIGHT_CARRY = 4'h0,
    OP_ARITH_SHIFT_RIGHT  = 4'h1,
    OP_SWAP_NIBBLES       = 4'h2,
    OP_STATUS_BIT_SET     = 4'h3,
    OP_STATUS_BIT_CLEAR   = 4'h4,
    OP_STORE_BIT_TO_T     = 4'h5,
    OP_LOAD_BIT_FROM_T    = 4'h6,
    OP_CARRY_SET          = 4'h7,
    OP_CARRY_CLEAR        = 4'h8,
    OP_NEGATIVE_SET       = 4'h9,
    OP_NEGATIVE_CLEAR     = 4'ha,
    OP_ZERO_SET           = 4'hb,
    OP_ZERO_CLEAR         = 4'hc,
    OP_IRQ_GLOBAL_ON      = 4'hd,
    OP_IRQ_GLOBAL_OFF     = 4'he,
    OP_SIGN_SET           = 4'hf
  } bsf_op_t;

  typedef struct packed {
    bsf_op_t    op;
    logic [2:0] bitsel;
    logic [7:0] dest;
    logic [7:0] src;
    logic [7:0] flags;
  } bsf_alu_in_t;

  typedef struct packed {
    logic [7:0] dest;
    logic [7:0] flags;
  } bsf_alu_out_t;

  typedef struct packed {
    logic               wr_pend;
    logic [2:0]         wr_sel;
    logic [7:0]         dest;
    logic [7:0]         src;
    logic [7:0]         flags;
    bsf_op_t            cmd_op;
    logic [2:0]         cmd_bit;
    logic [COUNT_W-1:0] count;
    logic [31:0]        rdata;
    logic               ready;
  } bsf_state_t;

endpackage

//--- src/bsf_top.sv
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module bsf_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire  logic              hclk,
  input  wire  logic              hresetn,
  // AHB-Lite slave
  input  wire  logic              hsel,
  input  wire  logic [ADDR_W-1:0] haddr,
  input  wire  logic [1:0]        htrans,
  input  wire  logic              hwrite,
  input  wire  logic [2:0]        hsize,
  input  wire  logic [31:0]       hwdata,
  input  wire  logic              hready,
  output var   logic [31:0]       hrdata,
  output var   logic              hreadyout,
  output var   logic              hresp,
  // Core view of the datapath
  output var   logic [7:0]        dest_value,
  output var   logic [7:0]        src_value,
  output var   logic [7:0]        flags_value,
  output var   logic              irq_enable
);
  import bsf_pkg::*;

  // ==========================================
  // Parameter check
  // ==========================================
  if (ADDR_W <= ADDR_LO || ADDR_W > 32) begin : g_bad_addr_w
    $error("bsf_top: ADDR_W must be 6 to 32");
  end

  // ==========================================
  // State and datapath
  // ==========================================
  bsf_state_t   s_q;
  bsf_state_t   s_d;
  bsf_alu_in_t  alu_in;
  bsf_alu_out_t alu_out;
  logic         accept;
  logic         hit;
  logic [2:0]   sel;
  logic         exec_go;
  bsf_op_t      exec_op;
  logic [2:0]   exec_bit;
  logic         src_bit;

  bsf_alu u_alu (
    .a (alu_in),
    .y (alu_out)
  );

  assign sel      = haddr[4:2];
  assign accept   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
  assign hit      = (haddr >> ADDR_LO) == '0 && haddr[1:0] == 2'h0
                    && hsize == HSIZE_WORD && sel <= OFS_COUNT[4:2];
  assign exec_go  = s_q.wr_pend && s_q.wr_sel == OFS_CMD[4:2];
  assign exec_op  = bsf_op_t'(hwdata[CMD_OP_LSB +: 4]);
  assign exec_bit = hwdata[CMD_BIT_LSB +: 3];
  assign src_bit  = s_q.src[exec_bit];

  always_comb begin
    alu_in.op     = exec_op;
    alu_in.bitsel = exec_bit;
    alu_in.dest   = s_q.dest;
    alu_in.src    = s_q.src;
    alu_in.flags  = s_q.flags;
  end

  always_comb begin
    s_d       = s_q;
    s_d.ready = 1'b1;
    // Data phase of a write
    if (s_q.wr_pend) begin
      unique case (s_q.wr_sel)
        OFS_DEST[4:2]:  s_d.dest  = hwdata[7:0];
        OFS_SRC[4:2]:   s_d.src   = hwdata[7:0];
        OFS_FLAGS[4:2]: s_d.flags = hwdata[7:0];
        OFS_CMD[4:2]: begin
          // Operation completes at this edge
          s_d.dest    = alu_out.dest;
          s_d.flags   = alu_out.flags;
          s_d.cmd_op  = exec_op;
          s_d.cmd_bit = exec_bit;
          s_d.count   = s_q.count + 1'b1;
        end
        default: ;
      endcase
    end
    // Address phase
    s_d.wr_pend = accept && hwrite && hit;
    s_d.wr_sel  = sel;
    s_d.rdata   = RST_WORD;
    if (accept && !hwrite && hit) begin
      // Read sees the write of the previous data phase
      unique case (sel)
        OFS_DEST[4:2]:  s_d.rdata[7:0] = s_d.dest;
        OFS_SRC[4:2]:   s_d.rdata[7:0] = s_d.src;
        OFS_FLAGS[4:2]: s_d.rdata[7:0] = s_d.flags;
        OFS_CMD[4:2]: begin
          s_d.rdata[CMD_OP_LSB +: 4]  = s_d.cmd_op;
          s_d.rdata[CMD_BIT_LSB +: 3] = s_d.cmd_bit;
        end
        OFS_COUNT[4:2]: s_d.rdata[COUNT_W-1:0] = s_d.count;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.wr_pend <= 1'b0;
      s_q.wr_sel  <= OFS_DEST[4:2];
      s_q.dest    <= RST_BYTE;
      s_q.src     <= RST_BYTE;
      s_q.flags   <= RST_BYTE;
      s_q.cmd_op  <= OP_ROTATE_RIGHT_CARRY;
      s_q.cmd_bit <= 3'h0;
      s_q.count   <= RST_COUNT;
      s_q.rdata   <= RST_WORD;
      s_q.ready   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign hrdata      = s_q.rdata;
  assign hreadyout   = s_q.ready;
  assign hresp       = HRESP_OKAY;
  assign dest_value  = s_q.dest;
  assign src_value   = s_q.src;
  assign flags_value = s_q.flags;
  assign irq_enable  = s_q.flags[FLAG_I];

  // ==========================================
  // Assertions
  // ==========================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_ROR: assert property (
    exec_go && exec_op == OP_ROTATE_RIGHT_CARRY |=>
      s_q.dest == {$past(s_q.flags[FLAG_C]), $past(s_q.dest[7:1])}
      && s_q.flags[FLAG_C] == $past(s_q.dest[0])
      && s_q.flags[FLAG_Z] == (s_q.dest == RST_BYTE)
      && s_q.flags[FLAG_N] == s_q.dest[7]
      && s_q.flags[FLAG_V] == (s_q.flags[FLAG_N] ^ s_q.flags[FLAG_C]))
    else $error("rotate right result wrong");

  AST_ASR: assert property (
    exec_go && exec_op == OP_ARITH_SHIFT_RIGHT |=>
      s_q.dest == {$past(s_q.dest[7]), $past(s_q.dest[7:1])}
      && s_q.flags[FLAG_C] == $past(s_q.dest[0])
      && s_q.flags[FLAG_Z] == (s_q.dest == RST_BYTE)
      && s_q.flags[FLAG_V] == (s_q.dest[7] ^ s_q.flags[FLAG_C]))
    else $error("arithmetic shift result wrong");

  AST_SWAP: assert property (
    exec_go && exec_op == OP_SWAP_NIBBLES |=>
      s_q.dest == {$past(s_q.dest[3:0]), $past(s_q.dest[7:4])}
      && s_q.flags == $past(s_q.flags))
    else $error("nibble swap wrong");

  AST_STATUS_BIT_SET: assert property (
    exec_go && exec_op == OP_STATUS_BIT_SET |=>
      s_q.flags == ($past(s_q.flags) | (8'h01 << $past(exec_bit))))
    else $error("status bit set wrong");

  AST_STATUS_BIT_CLEAR: assert property (
    exec_go && exec_op == OP_STATUS_BIT_CLEAR |=>
      s_q.flags == ($past(s_q.flags) & ~(8'h01 << $past(exec_bit))))
    else $error("status bit clear wrong");

  AST_BST: assert property (
    exec_go && exec_op == OP_STORE_BIT_TO_T |=>
      s_q.flags[FLAG_T] == $past(src_bit)
      && (s_q.flags | 8'h40) == ($past(s_q.flags) | 8'h40)
      && s_q.dest == $past(s_q.dest))
    else $error("bit store to transfer wrong");

  AST_BLD: assert property (
    exec_go && exec_op == OP_LOAD_BIT_FROM_T |=>
      s_q.dest[$past(exec_bit)] == $past(s_q.flags[FLAG_T])
      && s_q.flags == $past(s_q.flags))
    else $error("bit load from transfer wrong");

  AST_SEC: assert property (
    exec_go && exec_op == OP_CARRY_SET |=> s_q.flags == ($past(s_q.flags) | 8'h01))
    else $error("carry set wrong");

  AST_CLC: assert property (
    exec_go && exec_op == OP_CARRY_CLEAR |=> s_q.flags == ($past(s_q.flags) & 8'hfe))
    else $error("carry clear wrong");

  AST_SEN: assert property (
    exec_go && exec_op == OP_NEGATIVE_SET |=> s_q.flags == ($past(s_q.flags) | 8'h04))
    else $error("negative set wrong");

  AST_CLN: assert property (
    exec_go && exec_op == OP_NEGATIVE_CLEAR |=> s_q.flags == ($past(s_q.flags) & 8'hfb))
    else $error("negative clear wrong");

  AST_SEZ: assert property (
    exec_go && exec_op == OP_ZERO_SET |=> s_q.flags == ($past(s_q.flags) | 8'h02))
    else $error("zero set wrong");

  AST_CLZ: assert property (
    exec_go && exec_op == OP_ZERO_CLEAR |=> s_q.flags == ($past(s_q.flags) & 8'hfd))
    else $error("zero clear wrong");

  AST_SEI: assert property (
    exec_go && exec_op == OP_IRQ_GLOBAL_ON |=> irq_enable ##1 1'b1)
    else $error("global interrupt enable wrong");

  AST_CLI: assert property (
    exec_go && exec_op == OP_IRQ_GLOBAL_OFF |=> !irq_enable
      && s_q.flags[6:0] == $past(s_q.flags[6:0]))
    else $error("global interrupt disable wrong");

  AST_SES: assert property (
    exec_go && exec_op == OP_SIGN_SET |=> s_q.flags == ($past(s_q.flags) | 8'h10))
    else $error("sign set wrong");

  AST_COUNT: assert property (
    exec_go |=> s_q.count == $past(s_q.count) + 1'b1)
    else $error("operation count did not advance");

  AST_READY: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("slave must answer at once with OKAY");

  COV_ROR:  cover property (exec_go && exec_op == OP_ROTATE_RIGHT_CARRY ##1 exec_go);
  COV_BLD:  cover property (exec_go && exec_op == OP_STORE_BIT_TO_T
                            ##1 exec_go && exec_op == OP_LOAD_BIT_FROM_T);
  COV_SEI:  cover property (exec_go && exec_op == OP_IRQ_GLOBAL_ON ##1 irq_enable);
  COV_READ: cover property (accept && !hwrite && hit && sel == OFS_FLAGS[4:2]);

endmodule
`default_nettype wire

//--- verif/bit_shift_flag_ops_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Self-checking bench for the bit, shift and flag block
// ==========================================
module bit_shift_flag_ops_tb_top;
  import bsf_pkg::*;

  typedef struct packed {
    bsf_op_t    op;
    logic [2:0] b;
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] f;
    logic [7:0] ed;
    logic [7:0] ef;
  } bsf_row_t;

  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [7:0]  haddr   = 8'h00;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = HSIZE_WORD;
  logic [31:0] hwdata  = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  dest_value;
  logic [7:0]  src_value;
  logic [7:0]  flags_value;
  logic        irq_enable;
  int          n_fail  = 0;
  int          checked = 0;

  // One slave: its ready is the bus ready
  assign hready = hreadyout;

  always #2.5 hclk = ~hclk;

  bsf_top uut (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hready),
    .hrdata      (hrdata),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .dest_value  (dest_value),
    .src_value   (src_value),
    .flags_value (flags_value),
    .irq_enable  (irq_enable)
  );

  // Ordinary cases: op, bit, dest, src, flags in, dest and flags expected
  bsf_row_t rows [22] = '{
    '{OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0b},
    '{OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h80, 8'h00, 8'h31, 8'hc0, 8'h3c},
    '{OP_ARITH_SHIFT_RIGHT,  3'h0, 8'h81, 8'h00, 8'h00, 8'hc0, 8'h05},
    '{OP_ARITH_SHIFT_RIGHT,  3'h0, 8'h02, 8'h00, 8'hff, 8'h01, 8'hf0},
    '{OP_SWAP_NIBBLES,       3'h0, 8'h1e, 8'h00, 8'h5a, 8'he1, 8'h5a},
    '{OP_STATUS_BIT_SET,     3'h5, 8'h77, 8'h00, 8'h00, 8'h77, 8'h20},
    '{OP_STATUS_BIT_SET,     3'h7, 8'h77, 8'h00, 8'h7f, 8'h77, 8'hff},
    '{OP_STATUS_BIT_CLEAR,   3'h0, 8'h77, 8'h00, 8'hff, 8'h77, 8'hfe},
    '{OP_STATUS_BIT_CLEAR,   3'h6, 8'h77, 8'h00, 8'hff, 8'h77, 8'hbf},
    '{OP_STORE_BIT_TO_T,     3'h3, 8'h55, 8'h08, 8'h00, 8'h55, 8'h40},
    '{OP_STORE_BIT_TO_T,     3'h3, 8'h55, 8'hf7, 8'hff, 8'h55, 8'hbf},
    '{OP_LOAD_BIT_FROM_T,    3'h4, 8'h00, 8'h00, 8'h40, 8'h10, 8'h40},
    '{OP_LOAD_BIT_FROM_T,    3'h7, 8'hff, 8'h00, 8'hbf, 8'h7f, 8'hbf},
    '{OP_CARRY_SET,          3'h0, 8'h33, 8'h00, 8'h00, 8'h33, 8'h01},
    '{OP_CARRY_CLEAR,        3'h0, 8'h33, 8'h00, 8'hff, 8'h33, 8'hfe},
    '{OP_NEGATIVE_SET,       3'h0, 8'h33, 8'h00, 8'h00, 8'h33, 8'h04},
    '{OP_NEGATIVE_CLEAR,     3'h0, 8'h33, 8'h00, 8'hff, 8'h33, 8'hfb},
    '{OP_ZERO_SET,           3'h0, 8'h33, 8'h00, 8'h00, 8'h33, 8'h02},
    '{OP_ZERO_CLEAR,         3'h0, 8'h33, 8'h00, 8'hff, 8'h33, 8'hfd},
    '{OP_IRQ_GLOBAL_ON,      3'h0, 8'h33, 8'h00, 8'h00, 8'h33, 8'h80},
    '{OP_IRQ_GLOBAL_OFF,     3'h0, 8'h33, 8'h00, 8'hff, 8'h33, 8'h7f},
    '{OP_SIGN_SET,           3'h0, 8'h33, 8'h00, 8'h00, 8'h33, 8'h10}
  };

  // ==========================================
  // Bus and check tasks
  // ==========================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Address phase until ready, then data phase until ready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    logic r;
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    do begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end while (r !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do begin
      @(negedge hclk);
      r  = hreadyout;
      rd = hrdata;
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(a, 1'b1, d, dummy);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    xfer(a, 1'b0, 32'h0, d);
    chk(d, exp, msg);
  endtask

  task automatic run_op(input bsf_op_t op, input logic [2:0] b);
    wr(OFS_CMD, (32'(op) << CMD_OP_LSB) | (32'(b) << CMD_BIT_LSB));
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // Watchdog
  // ==========================================
  initial begin
    #25000;
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    test_done();
  end

  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(OFS_DEST, RST_WORD, "reset dest");
    rdchk(OFS_FLAGS, RST_WORD, "reset flags");
    rdchk(OFS_COUNT, RST_WORD, "reset count");
    $display("test reset done");

    foreach (rows[i]) begin
      wr(OFS_DEST, {24'h0, rows[i].d});
      wr(OFS_SRC, {24'h0, rows[i].s});
      wr(OFS_FLAGS, {24'h0, rows[i].f});
      run_op(rows[i].op, rows[i].b);
      @(negedge hclk);
      chk({24'h0, dest_value}, {24'h0, rows[i].ed}, "dest port");
      chk({24'h0, flags_value}, {24'h0, rows[i].ef}, "flags port");
      chk({31'h0, irq_enable}, {31'h0, rows[i].ef[FLAG_I]}, "irq port");
      rdchk(OFS_FLAGS, {24'h0, rows[i].ef}, "flags read");
      rdchk(OFS_SRC, {24'h0, rows[i].s}, "src kept");
    end
    rdchk(OFS_COUNT, 32'd22, "op count");
    rdchk(OFS_CMD, 32'h0000_000f, "last cmd");
    $display("test table done");

    // Back-to-back ops accumulate flag changes
    wr(OFS_FLAGS, 32'h0);
    run_op(OP_CARRY_SET, 3'h0);
    run_op(OP_IRQ_GLOBAL_ON, 3'h0);
    run_op(OP_STATUS_BIT_SET, 3'h6);
    @(negedge hclk);
    chk({31'h0, irq_enable}, 32'h1, "irq after on");
    rdchk(OFS_FLAGS, 32'h0000_00c1, "flags chain");
    run_op(OP_IRQ_GLOBAL_OFF, 3'h0);
    run_op(OP_STATUS_BIT_CLEAR, 3'h0);
    rdchk(OFS_FLAGS, 32'h0000_0040, "flags chain off");
    $display("test back to back done");

    // Unmapped, unaligned and read-only places
    wr(8'h14, 32'h0000_00aa);
    rdchk(8'h14, 32'h0, "unmapped read");
    rdchk(8'h02, 32'h0, "unaligned read");
    wr(OFS_COUNT, 32'h0000_1234);
    rdchk(OFS_COUNT, 32'd27, "count read only");
    $display("test unmapped done");

    // Second reset in mid-run
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk({24'h0, flags_value}, {24'h0, RST_BYTE}, "flags in reset");
    chk({31'h0, hreadyout}, 32'h1, "ready in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(OFS_COUNT, 32'h0, "count after reset");
    rdchk(OFS_CMD, 32'h0, "cmd after reset");
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
